// ==== rtl/adcid_regs.sv ====
// Identification, status and mode registers of the converter, AHB-Lite
// What this block does
// - identity word top nibble fixed, low byte a revision code
// - identity channel-count field always reads six, read-only
// - status word at index 01h, read-only, resets to 0500h
// - status bit 15 shows interface lock, unlocked after reset
// - status bit 14 sets on every converter resynchronisation
// - status bit 13 shows a change of the register-map checksum
// - status bit 12 shows an input checksum error
// - status bit 11 shows checksum type, 0 CCITT, 1 ANSI
// - status bit 10 reads 1 after a reset
// - status bits 9:8 show data word length, default 24 bits
// - status bits 5:0 show new data per channel, reset 0
// - status bits 7:6 always read zero
// - mode word at index 02h, resets to 0510h
// - writing 0 to mode reset bit clears the status reset flag
// - input checksum error only flagged while input checksum enabled
`timescale 1ns/10ps
module adcid_regs
    import adcid_pkg::*;
#(
    parameter logic [3:0] ID_NIBBLE = 4'h5, // arbitrary value
    parameter logic [7:0] ID_REVISION = 8'h01 // arbitrary value
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADCID_ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [ADCID_DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [ADCID_DATA_W-1:0] hrdata,
    input wire logic link_locked,
    input wire logic resync_pulse,
    input wire logic regmap_crc_change_pulse,
    input wire logic rx_crc_err_pulse,
    input wire logic [ADCID_CH_N-1:0] new_data_pulse,
    input wire logic [ADCID_CH_N-1:0] data_taken_pulse,
    output logic [ADCID_REG_W-1:0] mode_word,
    output logic [ADCID_REG_W-1:0] status_word,
    output logic irq
);
    typedef struct packed {
        logic wr_pend;
        logic [ADCID_ADDR_W-1:0] wr_addr;
        logic [ADCID_DATA_W-1:0] rd_data;
        logic [ADCID_REG_W-1:0] mode;
        logic [ADCID_IRQ_W-1:0] irq_mask;
    } adcid_regs_type;

    adcid_regs_type st;
    adcid_regs_type next_st;
    logic lock_sync;
    logic addr_phase;
    logic rd_status;
    logic wr_irq_stat;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    logic [2:0] ev_flag;
    logic [ADCID_CH_N-1:0] nd_flag;
    logic [ADCID_IRQ_W-1:0] irq_set;
    logic [ADCID_IRQ_W-1:0] irq_clr;
    logic [ADCID_IRQ_W-1:0] irq_stat;
    logic [ADCID_REG_W-1:0] id_word;

    // Lock level comes from the serial clock domain
    adcid_sync #(
        .WIDTH(1)
    ) u_lock_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(link_locked),
        .sync_out(lock_sync)
    );

    assign addr_phase = hsel & htrans[1] & hready;
    assign rd_status = addr_phase & ~hwrite & (haddr == ADCID_ADDR_STATUS);
    assign wr_irq_stat = st.wr_pend & (st.wr_addr == ADCID_ADDR_IRQ_STAT);

    assign ev_set[0] = resync_pulse;
    // checksum change, gated by map checksum enable
    assign ev_set[1] = regmap_crc_change_pulse
        & st.mode[ADCID_MD_REG_CRC_EN];
    assign ev_set[2] = rx_crc_err_pulse & st.mode[ADCID_MD_RX_CRC_EN];
    // Event flags clear on a status read; a new event still wins
    assign ev_clr = {3{rd_status}};

    adcid_flag #(
        .WIDTH(3)
    ) u_ev_flags (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(ev_set),
        .clr(ev_clr),
        .flag(ev_flag)
    );

    adcid_flag #(
        .WIDTH(ADCID_CH_N)
    ) u_nd_flags (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(new_data_pulse),
        .clr(data_taken_pulse),
        .flag(nd_flag)
    );

    assign irq_set[ADCID_IRQ_RESYNC] = ev_set[0];
    assign irq_set[ADCID_IRQ_REGMAP] = ev_set[1];
    assign irq_set[ADCID_IRQ_CRC_ERR] = ev_set[2];
    assign irq_set[ADCID_IRQ_NEW_DATA] = |new_data_pulse;
    assign irq_clr = wr_irq_stat ? hwdata[ADCID_IRQ_W-1:0] : '0;

    adcid_flag #(
        .WIDTH(ADCID_IRQ_W)
    ) u_irq_flags (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(irq_set),
        .clr(irq_clr),
        .flag(irq_stat)
    );

    assign id_word = {ID_NIBBLE, ADCID_CHANNEL_COUNT, ID_REVISION};

    always_comb
    begin
        status_word = '0;
        status_word[ADCID_ST_LOCK] = lock_sync;
        status_word[ADCID_ST_RESYNC] = ev_flag[0];
        status_word[ADCID_ST_REGMAP] = ev_flag[1];
        status_word[ADCID_ST_CRC_ERR] = ev_flag[2];
        status_word[ADCID_ST_CRC_TYPE] = st.mode[ADCID_MD_CRC_TYPE];
        status_word[ADCID_ST_RESET] = st.mode[ADCID_MD_RESET];
        status_word[ADCID_ST_WLEN_LO +: 2] = st.mode[ADCID_MD_WLEN_LO +: 2];
        status_word[ADCID_ST_RSV_LO +: 2] = 2'h0;
        status_word[ADCID_CH_N-1:0] = nd_flag;
    end

    always_comb
    begin
        next_st = st;
        next_st.wr_pend = addr_phase & hwrite;
        if (addr_phase)
        begin
            next_st.wr_addr = haddr;
        end
        // Read data is latched in the address phase, so no wait states
        if (addr_phase & ~hwrite)
        begin
            case (haddr)
                ADCID_ADDR_IDENTITY:
                    next_st.rd_data = {16'h0000, id_word};
                ADCID_ADDR_STATUS:
                    next_st.rd_data = {16'h0000, status_word};
                ADCID_ADDR_MODE:
                    next_st.rd_data = {16'h0000, st.mode};
                ADCID_ADDR_IRQ_STAT:
                    next_st.rd_data = {28'h0000000, irq_stat};
                ADCID_ADDR_IRQ_MASK:
                    next_st.rd_data = {28'h0000000, st.irq_mask};
                default:
                    next_st.rd_data = '0;
            endcase
        end
        if (st.wr_pend)
        begin
            case (st.wr_addr)
                ADCID_ADDR_MODE:
                begin
                    next_st.mode = hwdata[ADCID_REG_W-1:0] & ADCID_MODE_WMASK;
                    // reset bit only clears, never sets
                    next_st.mode[ADCID_MD_RESET] = st.mode[ADCID_MD_RESET]
                        & hwdata[ADCID_MD_RESET];
                end
                ADCID_ADDR_IRQ_MASK:
                    next_st.irq_mask = hwdata[ADCID_IRQ_W-1:0];
                default:
                    next_st.irq_mask = st.irq_mask;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st <= '{default: '0, mode: ADCID_MODE_RESET};
        else
            st <= next_st;
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rd_data;
    assign mode_word = st.mode;
    assign irq = |(irq_stat & st.irq_mask);

    sequence s_read(logic [ADCID_ADDR_W-1:0] a);
        addr_phase && !hwrite && haddr == a;
    endsequence

    sequence s_write_data(logic [ADCID_ADDR_W-1:0] a);
        st.wr_pend && st.wr_addr == a;
    endsequence

    property p_id_nibble;
        @(posedge hclk) disable iff (!hresetn)
        s_read(ADCID_ADDR_IDENTITY) |=>
            hrdata[15:12] == ID_NIBBLE && hrdata[7:0] == ID_REVISION;
    endproperty
    a_id_nibble: assert property (p_id_nibble)
        else $error("identity nibble or revision wrong");

    property p_id_count;
        @(posedge hclk) disable iff (!hresetn)
        s_read(ADCID_ADDR_IDENTITY) |=> hrdata[11:8] == ADCID_CHANNEL_COUNT;
    endproperty
    a_id_count: assert property (p_id_count)
        else $error("channel count not six");

    property p_status_rsv;
        @(posedge hclk) disable iff (!hresetn)
        s_read(ADCID_ADDR_STATUS) |=> hrdata[7:6] == 2'h0
            && hrdata[ADCID_ST_LOCK] == $past(lock_sync);
    endproperty
    a_status_rsv: assert property (p_status_rsv)
        else $error("status reserved or lock bit wrong");

    property p_resync_set;
        @(posedge hclk) disable iff (!hresetn)
        resync_pulse |=> status_word[ADCID_ST_RESYNC];
    endproperty
    a_resync_set: assert property (p_resync_set)
        else $error("resync flag not set");

    property p_resync_read;
        @(posedge hclk) disable iff (!hresetn)
        resync_pulse ##1 s_read(ADCID_ADDR_STATUS) |=>
            hrdata[ADCID_ST_RESYNC];
    endproperty
    a_resync_read: assert property (p_resync_read)
        else $error("resync flag not read back");

    property p_crc_gate;
        @(posedge hclk) disable iff (!hresetn)
        rx_crc_err_pulse && !st.mode[ADCID_MD_RX_CRC_EN]
            && !status_word[ADCID_ST_CRC_ERR] |=>
            !status_word[ADCID_ST_CRC_ERR];
    endproperty
    a_crc_gate: assert property (p_crc_gate)
        else $error("crc error flagged while disabled");

    property p_crc_set;
        @(posedge hclk) disable iff (!hresetn)
        rx_crc_err_pulse && st.mode[ADCID_MD_RX_CRC_EN] |=>
            status_word[ADCID_ST_CRC_ERR];
    endproperty
    a_crc_set: assert property (p_crc_set)
        else $error("crc error not flagged");

    property p_reset_clear;
        @(posedge hclk) disable iff (!hresetn)
        s_write_data(ADCID_ADDR_MODE) and !hwdata[ADCID_MD_RESET] |=>
            !status_word[ADCID_ST_RESET] [*2];
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset flag not cleared");

    property p_wlen;
        @(posedge hclk) disable iff (!hresetn)
        s_write_data(ADCID_ADDR_MODE) |=>
            status_word[9:8] == $past(hwdata[9:8])
            && status_word[ADCID_ST_CRC_TYPE] == $past(hwdata[11]);
    endproperty
    a_wlen: assert property (p_wlen)
        else $error("word length or crc type not mirrored");

    property p_ro_write;
        @(posedge hclk) disable iff (!hresetn)
        s_write_data(ADCID_ADDR_STATUS) and (!rd_status && !resync_pulse
            && !regmap_crc_change_pulse && !rx_crc_err_pulse
            && new_data_pulse == '0 && data_taken_pulse == '0)
            |=> $stable(status_word[ADCID_ST_LOCK-1:0]);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("status changed by a write");

    property p_new_data;
        @(posedge hclk) disable iff (!hresetn)
        new_data_pulse[0] |=> status_word[0] && irq_stat[ADCID_IRQ_NEW_DATA];
    endproperty
    a_new_data: assert property (p_new_data)
        else $error("new data flag not set");

    property p_irq_level;
        @(posedge hclk) disable iff (!hresetn)
        (irq_set & st.irq_mask) != '0
            && !(st.wr_pend && st.wr_addr == ADCID_ADDR_IRQ_MASK) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt not raised");
endmodule

// ==== common/adcid_pkg.sv ====
// Register map and field layout of the converter id/status bank
package adcid_pkg;
    localparam int ADCID_DATA_W = 32;
    localparam int ADCID_ADDR_W = 12;
    localparam int ADCID_REG_W = 16;
    localparam int ADCID_CH_N = 6;
    localparam int ADCID_IRQ_W = 4;
    // Register indices; byte address is four times the index
    localparam logic [9:0] ADCID_IDX_IDENTITY = 10'h000;
    localparam logic [9:0] ADCID_IDX_STATUS = 10'h001;
    localparam logic [9:0] ADCID_IDX_MODE = 10'h002;
    localparam logic [9:0] ADCID_IDX_IRQ_STAT = 10'h010;
    localparam logic [9:0] ADCID_IDX_IRQ_MASK = 10'h011;
    localparam logic [11:0] ADCID_ADDR_IDENTITY = {ADCID_IDX_IDENTITY, 2'h0};
    localparam logic [11:0] ADCID_ADDR_STATUS = {ADCID_IDX_STATUS, 2'h0};
    localparam logic [11:0] ADCID_ADDR_MODE = {ADCID_IDX_MODE, 2'h0};
    localparam logic [11:0] ADCID_ADDR_IRQ_STAT = {ADCID_IDX_IRQ_STAT, 2'h0};
    localparam logic [11:0] ADCID_ADDR_IRQ_MASK = {ADCID_IDX_IRQ_MASK, 2'h0};
    // Identity word fields
    localparam logic [3:0] ADCID_CHANNEL_COUNT = 4'h6;
    // Status word bit positions
    localparam int ADCID_ST_LOCK = 15;
    localparam int ADCID_ST_RESYNC = 14;
    localparam int ADCID_ST_REGMAP = 13;
    localparam int ADCID_ST_CRC_ERR = 12;
    localparam int ADCID_ST_CRC_TYPE = 11;
    localparam int ADCID_ST_RESET = 10;
    localparam int ADCID_ST_WLEN_LO = 8;
    localparam int ADCID_ST_RSV_LO = 6;
    localparam logic [15:0] ADCID_STATUS_RESET = 16'h0500;
    // Mode word bit positions and reset value
    localparam int ADCID_MD_REG_CRC_EN = 13;
    localparam int ADCID_MD_RX_CRC_EN = 12;
    localparam int ADCID_MD_CRC_TYPE = 11;
    localparam int ADCID_MD_RESET = 10;
    localparam int ADCID_MD_WLEN_LO = 8;
    localparam logic [15:0] ADCID_MODE_RESET = 16'h0510;
    localparam logic [15:0] ADCID_MODE_WMASK = 16'h3fff;
    // Interrupt status/mask bits
    localparam int ADCID_IRQ_RESYNC = 0;
    localparam int ADCID_IRQ_REGMAP = 1;
    localparam int ADCID_IRQ_CRC_ERR = 2;
    localparam int ADCID_IRQ_NEW_DATA = 3;
    localparam logic [1:0] ADCID_HTRANS_NONSEQ = 2'h2;
endpackage

// ==== rtl/adcid_sync.sv ====
// Two-stage synchroniser for levels from another clock domain
`timescale 1ns/10ps
module adcid_sync #(
    parameter int WIDTH = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } adcid_sync_type;

    adcid_sync_type st;
    adcid_sync_type next_st;

    // First stage feeds only the second stage
    always_comb
    begin
        next_st.meta = async_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign sync_out = st.stable;
endmodule

// ==== rtl/adcid_flag.sv ====
// Bank of sticky flags where a set beats a same-cycle clear
`timescale 1ns/10ps
module adcid_flag #(
    parameter int WIDTH = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] flag
);
    typedef struct packed {
        logic [WIDTH-1:0] bits;
    } adcid_flag_type;

    adcid_flag_type st;
    adcid_flag_type next_st;

    // Set wins so an event in the clearing cycle is kept
    always_comb
    begin
        next_st.bits = (st.bits & ~clr) | set;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign flag = st.bits;
endmodule

// ==== testbench/adcid_conv_model.sv ====
// Behavioural converter side: lock level and one-cycle event pulses
`timescale 1ns/10ps
module adcid_conv_model
    import adcid_pkg::*;
(
    input wire logic hclk,
    output logic link_locked,
    output logic resync_pulse,
    output logic regmap_crc_change_pulse,
    output logic rx_crc_err_pulse,
    output logic [ADCID_CH_N-1:0] new_data_pulse,
    output logic [ADCID_CH_N-1:0] data_taken_pulse
);
    initial
    begin
        link_locked = 1'b0;
        resync_pulse = 1'b0;
        regmap_crc_change_pulse = 1'b0;
        rx_crc_err_pulse = 1'b0;
        new_data_pulse = 6'h00;
        data_taken_pulse = 6'h00;
    end

    // Lock is a level; the bank resynchronises it on its own
    task automatic lock(input logic on);
        link_locked <= on;
        @(posedge hclk);
    endtask

    // One cycle only, so each event is seen exactly once
    task automatic fire(input logic [2:0] ev, input logic [5:0] nd,
                        input logic [5:0] tk);
        resync_pulse <= ev[0];
        regmap_crc_change_pulse <= ev[1];
        rx_crc_err_pulse <= ev[2];
        new_data_pulse <= nd;
        data_taken_pulse <= tk;
        @(posedge hclk);
        resync_pulse <= 1'b0;
        regmap_crc_change_pulse <= 1'b0;
        rx_crc_err_pulse <= 1'b0;
        new_data_pulse <= 6'h00;
        data_taken_pulse <= 6'h00;
    endtask
endmodule

// ==== testbench/adc_id_status_registers_bench.sv ====
// Self-checking bench for the id/status register bank
`timescale 1ns/10ps
module adc_id_status_registers_bench import adcid_pkg::*;;
    localparam logic [3:0] ID_N = 4'ha; // arbitrary value
    localparam logic [7:0] ID_R = 8'h3c; // arbitrary value
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic link_locked;
    logic resync_pulse;
    logic regmap_crc_change_pulse;
    logic rx_crc_err_pulse;
    logic [5:0] new_data_pulse;
    logic [5:0] data_taken_pulse;
    logic [15:0] mode_word;
    logic [15:0] status_word;
    logic irq;
    logic [31:0] rd;
    logic [31:0] exp_w;
    int miscompares = 0;
    int n_checks = 0;

    always #5 hclk = ~hclk;

    adcid_regs #(.ID_NIBBLE(ID_N), .ID_REVISION(ID_R)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .link_locked(link_locked),
        .resync_pulse(resync_pulse),
        .regmap_crc_change_pulse(regmap_crc_change_pulse),
        .rx_crc_err_pulse(rx_crc_err_pulse),
        .new_data_pulse(new_data_pulse),
        .data_taken_pulse(data_taken_pulse), .mode_word(mode_word),
        .status_word(status_word), .irq(irq));

    adcid_conv_model conv_u (
        .hclk(hclk), .link_locked(link_locked),
        .resync_pulse(resync_pulse),
        .regmap_crc_change_pulse(regmap_crc_change_pulse),
        .rx_crc_err_pulse(rx_crc_err_pulse),
        .new_data_pulse(new_data_pulse),
        .data_taken_pulse(data_taken_pulse));

    task automatic close_out;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Never assume zero wait states: wait on hready at each phase
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= ADCID_HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
                        input string what);
        xfer(1'b0, a, 32'h00000000);
        chk(what, exp, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    initial
    begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        $display("watchdog expired");
        close_out();
    end

    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        exp_w = {16'h0, ID_N, 4'h6, ID_R};
        rchk(ADCID_ADDR_IDENTITY, exp_w, "id");
        rchk(ADCID_ADDR_STATUS, 32'h0500, "status");
        rchk(ADCID_ADDR_MODE, 32'h0510, "mode");
        wr(ADCID_ADDR_IDENTITY, 32'hffffffff);
        wr(ADCID_ADDR_STATUS, 32'hffffffff);
        rchk(ADCID_ADDR_IDENTITY, {16'h0, ID_N, 4'h6, ID_R}, "id");
        rchk(ADCID_ADDR_STATUS, 32'h0500, "status");
        conv_u.lock(1'b1);
        repeat (3) @(posedge hclk);
        rchk(ADCID_ADDR_STATUS, 32'h8500, "lock");
        chk("status port", 32'h8500, {16'h0, status_word});
        conv_u.fire(3'b001, 6'h00, 6'h00);
        rchk(ADCID_ADDR_STATUS, 32'hc500, "resync");
        rchk(ADCID_ADDR_STATUS, 32'h8500, "resync read");
        conv_u.fire(3'b100, 6'h00, 6'h00);
        rchk(ADCID_ADDR_STATUS, 32'h8500, "crc off");
        wr(ADCID_ADDR_MODE, 32'h1510);
        conv_u.fire(3'b100, 6'h00, 6'h00);
        rchk(ADCID_ADDR_STATUS, 32'h9500, "crc err");
        wr(ADCID_ADDR_MODE, 32'h2510);
        conv_u.fire(3'b010, 6'h00, 6'h00);
        rchk(ADCID_ADDR_STATUS, 32'ha500, "map crc");
        for (int i = 0; i < 8; i++)
        begin
            wr(ADCID_ADDR_MODE, {20'h0, i[2], 1'b1, i[1:0], 8'h10});
            exp_w = {20'h8, i[2], 1'b1, i[1:0], 8'h0};
            rchk(ADCID_ADDR_STATUS, exp_w, "mirror");
        end
        for (int c = 0; c < 6; c++)
        begin
            conv_u.fire(3'b000, 6'h01 << c, 6'h00);
            exp_w = 32'h8f00 | (32'h1 << c);
            rchk(ADCID_ADDR_STATUS, exp_w, "new data");
            conv_u.fire(3'b000, 6'h00, 6'h01 << c);
            rchk(ADCID_ADDR_STATUS, 32'h8f00, "taken");
        end
        wr(ADCID_ADDR_MODE, 32'h0b10);
        rchk(ADCID_ADDR_STATUS, 32'h8b00, "reset flag");
        rchk(ADCID_ADDR_MODE, 32'h0b10, "mode");
        wr(ADCID_ADDR_IRQ_STAT, 32'hf);
        wr(ADCID_ADDR_IRQ_MASK, 32'h1);
        conv_u.fire(3'b001, 6'h00, 6'h00);
        @(posedge hclk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(ADCID_ADDR_IRQ_STAT, 32'h1);
        @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(ADCID_ADDR_IRQ_MASK, 32'h0);
        conv_u.fire(3'b001, 6'h00, 6'h00);
        rchk(ADCID_ADDR_IRQ_STAT, 32'h1, "irq stat");
        @(posedge hclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rchk(12'h100, 32'h0, "unmapped");
        // Unlock first, so the synchroniser cannot refill bit 15
        conv_u.lock(1'b0);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("mode port", 32'h0510, {16'h0, mode_word});
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(ADCID_ADDR_STATUS, 32'h0500, "status");
        rchk(ADCID_ADDR_MODE, 32'h0510, "mode");
        close_out();
    end
endmodule
